// file: logic/config_bank_pkg.sv
// Shared constants and types for the logical device configuration bank
package config_bank_pkg;

  // ----------------------------------------------------------------
  // Register indices
  // ----------------------------------------------------------------
  localparam logic [7:0] IDX_CONFIG_CONTROL = 8'h02;
  localparam logic [7:0] IDX_LDN = 8'h07;
  localparam logic [7:0] IDX_DEVICE_ID = 8'h20;
  localparam logic [7:0] IDX_DEVICE_REV = 8'h21;
  localparam logic [7:0] IDX_POWER_CONTROL = 8'h22;
  localparam logic [7:0] IDX_TEST_REG_THREE = 8'h2f;
  localparam logic [7:0] IDX_GLOBAL_LIMIT = 8'h30;
  localparam logic [7:0] IDX_ACTIVATE = 8'h30;
  localparam logic [7:0] IDX_BASE_HIGH = 8'h60;
  localparam logic [7:0] IDX_BASE_LOW = 8'h61;
  localparam logic [7:0] IDX_ALT_BASE_HIGH = 8'h62;
  localparam logic [7:0] IDX_ALT_BASE_LOW = 8'h63;
  localparam logic [7:0] IDX_IRQ_SELECT = 8'h70;
  localparam logic [7:0] IDX_SECOND_IRQ_SELECT = 8'h72;
  localparam logic [7:0] IDX_DMA_SELECT = 8'h74;
  localparam logic [7:0] IDX_MODE = 8'hf0;
  localparam logic [7:0] IDX_OPTION = 8'hf1;
  localparam logic [7:0] IDX_EXTRA = 8'hf2;
  localparam logic [7:0] IDX_DRIVE_ZERO = 8'hf4;
  localparam logic [7:0] IDX_DRIVE_ONE = 8'hf5;

  // ----------------------------------------------------------------
  // Field positions and logical device numbers
  // ----------------------------------------------------------------
  localparam int SOFT_RESET_BIT = 0;
  localparam int ACTIVATE_BIT = 0;
  localparam logic [7:0] LDN_NONE = 8'h00;
  localparam logic [7:0] LDN_FLOPPY = 8'h00;
  localparam logic [7:0] LDN_PARALLEL = 8'h03;
  localparam logic [7:0] LDN_SERIAL_ONE = 8'h04;
  localparam logic [7:0] LDN_SERIAL_TWO = 8'h05;
  localparam logic [7:0] LDN_KEYBOARD = 8'h07;
  localparam logic [7:0] LDN_GAME = 8'h09;
  localparam logic [7:0] LDN_RUNTIME = 8'h0a;
  localparam logic [7:0] LDN_MIDI = 8'h0b;

  // ----------------------------------------------------------------
  // Reset values and standby-only bit masks
  // ----------------------------------------------------------------
  localparam logic [7:0] RST_ZERO = 8'h00;
  localparam logic [7:0] RST_FLOPPY_BASE_HIGH = 8'h03;
  localparam logic [7:0] RST_FLOPPY_BASE_LOW = 8'hf0;
  localparam logic [7:0] RST_FLOPPY_IRQ = 8'h06;
  localparam logic [7:0] RST_FLOPPY_DMA = 8'h02;
  localparam logic [7:0] RST_FLOPPY_MODE = 8'h0e;
  localparam logic [7:0] RST_FLOPPY_TYPE = 8'hff;
  localparam logic [7:0] RST_PARALLEL_DMA = 8'h04;
  localparam logic [7:0] RST_PARALLEL_MODE = 8'h3c;
  localparam logic [7:0] RST_SERIAL_TWO_DMA = 8'h04;
  localparam logic [7:0] RST_INFRARED_OPTIONS = 8'h02;
  localparam logic [7:0] RST_INFRARED_TIMEOUT = 8'h03;
  localparam logic [7:0] RST_MIDI_BASE_HIGH = 8'h03;
  localparam logic [7:0] RST_MIDI_BASE_LOW = 8'h30;
  localparam logic [7:0] RST_MIDI_IRQ = 8'h05;
  localparam logic [7:0] MASK_NONE = 8'h00;
  localparam logic [7:0] MASK_POWER_STANDBY = 8'ha0;
  localparam logic [7:0] MASK_KEYBOARD_STANDBY = 8'h60;

  localparam int NUM_REGS = 49;
  localparam int NUM_UNITS = 8;

  // ----------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------
  // Which reset sources load an entry
  typedef enum logic [3:0] {
    KIND_ALL = 4'b0001,
    KIND_COLD = 4'b0010,
    KIND_POR = 4'b0100,
    KIND_STANDBY = 4'b1000
  } rst_kind_t;

  typedef struct packed {
    logic is_global;
    logic [7:0] ldn;
    logic [7:0] idx;
    logic [7:0] rst;
    logic [7:0] standby_mask;
    rst_kind_t kind;
  } reg_entry_t;

  typedef struct packed {
    logic strobe;
    logic write;
    logic data_port;
    logic [7:0] wdata;
  } cfg_req_t;

  typedef struct packed {
    logic active;
    logic [7:0] base_high;
    logic [7:0] base_low;
    logic [7:0] irq_select;
    logic [7:0] dma_select;
    logic [7:0] mode;
  } unit_cfg_t;

  typedef struct packed {
    logic [7:0] power_control;
    logic [7:0] test_reg_three;
    logic [7:0] keyboard_reset_gate_select;
    logic [7:0] mouse_irq_select;
    logic [7:0] infrared_base_high;
    logic [7:0] infrared_base_low;
    logic [7:0] slow_clock_control;
    logic [7:0] floppy_on_parallel_select;
  } aux_cfg_t;

endpackage

// file: logic/logical_device_config_bank.sv
// Index/data configuration register bank for all logical devices
`timescale 1ns/1ps

module logical_device_config_bank
  import config_bank_pkg::*;
#(
  parameter logic [7:0] DEVICE_ID = 8'h5a,  // Arbitrary value
  parameter logic [7:0] DEVICE_REV = 8'h01  // Arbitrary value
) (
  input wire logic ref_clk,
  input wire logic reset,
  input wire logic main_supply_por,
  input wire logic standby_supply_power_on_reset,
  input wire logic config_enable,
  input wire cfg_req_t cfg_req,
  output logic [7:0] cfg_rdata,
  output logic cfg_rvalid,
  output logic [7:0] logical_device_q,
  output logic soft_reset_pulse,
  output unit_cfg_t [NUM_UNITS-1:0] unit_cfg,
  output aux_cfg_t aux_cfg
);

  // ----------------------------------------------------------------
  // Register table
  // ----------------------------------------------------------------
  localparam reg_entry_t TABLE [NUM_REGS] = '{
    '{1'b1, LDN_NONE, IDX_POWER_CONTROL, RST_ZERO, MASK_POWER_STANDBY, KIND_ALL},
    '{1'b1, LDN_NONE, IDX_TEST_REG_THREE, RST_ZERO, MASK_NONE, KIND_POR},
    '{1'b0, LDN_FLOPPY, IDX_ACTIVATE, RST_ZERO, MASK_NONE, KIND_ALL},
    '{1'b0, LDN_FLOPPY, IDX_BASE_HIGH, RST_FLOPPY_BASE_HIGH, MASK_NONE, KIND_ALL},
    '{1'b0, LDN_FLOPPY, IDX_BASE_LOW, RST_FLOPPY_BASE_LOW, MASK_NONE, KIND_ALL},
    '{1'b0, LDN_FLOPPY, IDX_IRQ_SELECT, RST_FLOPPY_IRQ, MASK_NONE, KIND_ALL},
    '{1'b0, LDN_FLOPPY, IDX_DMA_SELECT, RST_FLOPPY_DMA, MASK_NONE, KIND_ALL},
    '{1'b0, LDN_FLOPPY, IDX_MODE, RST_FLOPPY_MODE, MASK_NONE, KIND_COLD},
    '{1'b0, LDN_FLOPPY, IDX_OPTION, RST_ZERO, MASK_NONE, KIND_COLD},
    '{1'b0, LDN_FLOPPY, IDX_EXTRA, RST_FLOPPY_TYPE, MASK_NONE, KIND_COLD},
    '{1'b0, LDN_FLOPPY, IDX_DRIVE_ZERO, RST_ZERO, MASK_NONE, KIND_COLD},
    '{1'b0, LDN_FLOPPY, IDX_DRIVE_ONE, RST_ZERO, MASK_NONE, KIND_COLD},
    '{1'b0, LDN_PARALLEL, IDX_ACTIVATE, RST_ZERO, MASK_NONE, KIND_ALL},
    '{1'b0, LDN_PARALLEL, IDX_BASE_HIGH, RST_ZERO, MASK_NONE, KIND_ALL},
    '{1'b0, LDN_PARALLEL, IDX_BASE_LOW, RST_ZERO, MASK_NONE, KIND_ALL},
    '{1'b0, LDN_PARALLEL, IDX_IRQ_SELECT, RST_ZERO, MASK_NONE, KIND_ALL},
    '{1'b0, LDN_PARALLEL, IDX_DMA_SELECT, RST_PARALLEL_DMA, MASK_NONE, KIND_ALL},
    '{1'b0, LDN_PARALLEL, IDX_MODE, RST_PARALLEL_MODE, MASK_NONE, KIND_COLD},
    '{1'b0, LDN_PARALLEL, IDX_OPTION, RST_ZERO, MASK_NONE, KIND_COLD},
    '{1'b0, LDN_SERIAL_ONE, IDX_ACTIVATE, RST_ZERO, MASK_NONE, KIND_ALL},
    '{1'b0, LDN_SERIAL_ONE, IDX_BASE_HIGH, RST_ZERO, MASK_NONE, KIND_ALL},
    '{1'b0, LDN_SERIAL_ONE, IDX_BASE_LOW, RST_ZERO, MASK_NONE, KIND_ALL},
    '{1'b0, LDN_SERIAL_ONE, IDX_IRQ_SELECT, RST_ZERO, MASK_NONE, KIND_ALL},
    '{1'b0, LDN_SERIAL_ONE, IDX_MODE, RST_ZERO, MASK_NONE, KIND_COLD},
    '{1'b0, LDN_SERIAL_TWO, IDX_BASE_HIGH, RST_ZERO, MASK_NONE, KIND_ALL},
    '{1'b0, LDN_SERIAL_TWO, IDX_BASE_LOW, RST_ZERO, MASK_NONE, KIND_ALL},
    '{1'b0, LDN_SERIAL_TWO, IDX_ALT_BASE_HIGH, RST_ZERO, MASK_NONE, KIND_ALL},
    '{1'b0, LDN_SERIAL_TWO, IDX_ALT_BASE_LOW, RST_ZERO, MASK_NONE, KIND_ALL},
    '{1'b0, LDN_SERIAL_TWO, IDX_IRQ_SELECT, RST_ZERO, MASK_NONE, KIND_ALL},
    '{1'b0, LDN_SERIAL_TWO, IDX_DMA_SELECT, RST_SERIAL_TWO_DMA, MASK_NONE, KIND_ALL},
    '{1'b0, LDN_SERIAL_TWO, IDX_MODE, RST_ZERO, MASK_NONE, KIND_COLD},
    '{1'b0, LDN_SERIAL_TWO, IDX_OPTION, RST_INFRARED_OPTIONS, MASK_NONE, KIND_COLD},
    '{1'b0, LDN_SERIAL_TWO, IDX_EXTRA, RST_INFRARED_TIMEOUT, MASK_NONE, KIND_COLD},
    '{1'b0, LDN_KEYBOARD, IDX_ACTIVATE, RST_ZERO, MASK_NONE, KIND_ALL},
    '{1'b0, LDN_KEYBOARD, IDX_IRQ_SELECT, RST_ZERO, MASK_NONE, KIND_ALL},
    '{1'b0, LDN_KEYBOARD, IDX_SECOND_IRQ_SELECT, RST_ZERO, MASK_NONE, KIND_ALL},
    '{1'b0, LDN_KEYBOARD, IDX_MODE, RST_ZERO, MASK_KEYBOARD_STANDBY, KIND_COLD},
    '{1'b0, LDN_GAME, IDX_ACTIVATE, RST_ZERO, MASK_NONE, KIND_ALL},
    '{1'b0, LDN_GAME, IDX_BASE_HIGH, RST_ZERO, MASK_NONE, KIND_ALL},
    '{1'b0, LDN_GAME, IDX_BASE_LOW, RST_ZERO, MASK_NONE, KIND_ALL},
    '{1'b0, LDN_RUNTIME, IDX_ACTIVATE, RST_ZERO, MASK_NONE, KIND_ALL},
    '{1'b0, LDN_RUNTIME, IDX_BASE_HIGH, RST_ZERO, MASK_NONE, KIND_ALL},
    '{1'b0, LDN_RUNTIME, IDX_BASE_LOW, RST_ZERO, MASK_NONE, KIND_ALL},
    '{1'b0, LDN_RUNTIME, IDX_MODE, RST_ZERO, MASK_NONE, KIND_STANDBY},
    '{1'b0, LDN_RUNTIME, IDX_OPTION, RST_ZERO, MASK_NONE, KIND_STANDBY},
    '{1'b0, LDN_MIDI, IDX_ACTIVATE, RST_ZERO, MASK_NONE, KIND_ALL},
    '{1'b0, LDN_MIDI, IDX_BASE_HIGH, RST_MIDI_BASE_HIGH, MASK_NONE, KIND_ALL},
    '{1'b0, LDN_MIDI, IDX_BASE_LOW, RST_MIDI_BASE_LOW, MASK_NONE, KIND_ALL},
    '{1'b0, LDN_MIDI, IDX_IRQ_SELECT, RST_MIDI_IRQ, MASK_NONE, KIND_ALL}
  };

  localparam logic [7:0] UNIT_LDN [NUM_UNITS] = '{
    LDN_FLOPPY, LDN_PARALLEL, LDN_SERIAL_ONE, LDN_SERIAL_TWO,
    LDN_KEYBOARD, LDN_GAME, LDN_RUNTIME, LDN_MIDI
  };

  // ----------------------------------------------------------------
  // Reset classes and port decode
  // ----------------------------------------------------------------
  logic soft_q;
  logic [7:0] index_q;
  logic [7:0] ldn_q;
  logic [7:0] regs_q [NUM_REGS];
  logic por_any;
  logic cold_any;
  logic all_any;
  logic port_access;
  logic index_wr;
  logic data_wr;
  logic data_rd;
  logic index_rd;
  logic global_sel;
  logic [7:0] read_value;

  assign por_any = main_supply_por | standby_supply_power_on_reset;
  assign cold_any = reset | por_any;
  assign all_any = cold_any | soft_q;

  // Ports only respond while the chip is in configuration mode
  assign port_access = cfg_req.strobe & config_enable;
  assign index_wr = port_access & cfg_req.write & ~cfg_req.data_port;
  assign data_wr = port_access & cfg_req.write & cfg_req.data_port;
  assign data_rd = port_access & ~cfg_req.write & cfg_req.data_port;
  assign index_rd = port_access & ~cfg_req.write & ~cfg_req.data_port;
  assign global_sel = index_q < IDX_GLOBAL_LIMIT;

  function automatic logic kind_fires(input rst_kind_t kind, input logic all_r, input logic cold_r,
                                      input logic por_r);
    logic fire;
    fire = 1'b0;
    unique case (kind)
      KIND_ALL: fire = all_r;
      KIND_COLD: fire = cold_r;
      KIND_POR: fire = por_r;
      KIND_STANDBY: fire = 1'b0;
    endcase
    return fire;
  endfunction

  // Entry lookup; ldn is ignored for chip-level entries
  function automatic logic [7:0] lookup(input logic is_global, input logic [7:0] ldn, input logic [7:0] idx);
    logic [7:0] value;
    value = RST_ZERO;
    for (int e = 0; e < NUM_REGS; e++) begin
      if (TABLE[e].idx == idx && TABLE[e].is_global == is_global &&
          (is_global || TABLE[e].ldn == ldn)) begin
        value = regs_q[e];
      end
    end
    return value;
  endfunction

  // ----------------------------------------------------------------
  // Index, device number and soft reset
  // ----------------------------------------------------------------
  always_ff @(posedge ref_clk) begin
    if (cold_any) begin
      index_q <= RST_ZERO;
    end else if (index_wr) begin
      index_q <= cfg_req.wdata;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (all_any) begin
      ldn_q <= RST_ZERO;
    end else if (data_wr && index_q == IDX_LDN) begin
      ldn_q <= cfg_req.wdata;
    end
  end

  // Registered so the reset lands one cycle after the write, never mid-write
  always_ff @(posedge ref_clk) begin
    if (cold_any) begin
      soft_q <= 1'b0;
    end else begin
      soft_q <= data_wr && index_q == IDX_CONFIG_CONTROL && cfg_req.wdata[SOFT_RESET_BIT];
    end
  end

  // ----------------------------------------------------------------
  // Storage, one flop byte per table entry
  // ----------------------------------------------------------------
  for (genvar g = 0; g < NUM_REGS; g++) begin : gen_entry
    logic hit;
    logic kind_hit;
    assign hit = data_wr && TABLE[g].idx == index_q &&
                 (TABLE[g].is_global ? global_sel : (!global_sel && TABLE[g].ldn == ldn_q));
    assign kind_hit = kind_fires(TABLE[g].kind, all_any, cold_any, por_any);

    always_ff @(posedge ref_clk) begin
      if (standby_supply_power_on_reset) begin
        regs_q[g] <= TABLE[g].rst;
      end else if (kind_hit) begin
        // Standby-only bits survive every other reset
        regs_q[g] <= (regs_q[g] & TABLE[g].standby_mask) | (TABLE[g].rst & ~TABLE[g].standby_mask);
      end else if (hit) begin
        regs_q[g] <= cfg_req.wdata;
      end
    end
  end

  // ----------------------------------------------------------------
  // Read path
  // ----------------------------------------------------------------
  always_comb begin
    read_value = lookup(global_sel, ldn_q, index_q);
    if (index_q == IDX_LDN) begin
      read_value = ldn_q;
    end else if (index_q == IDX_DEVICE_ID) begin
      read_value = DEVICE_ID;
    end else if (index_q == IDX_DEVICE_REV) begin
      read_value = DEVICE_REV;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (cold_any) begin
      cfg_rdata <= RST_ZERO;
      cfg_rvalid <= 1'b0;
    end else begin
      cfg_rvalid <= data_rd | index_rd;
      if (data_rd) begin
        cfg_rdata <= read_value;
      end else if (index_rd) begin
        cfg_rdata <= index_q;
      end
    end
  end

  // ----------------------------------------------------------------
  // Configuration outputs, registered
  // ----------------------------------------------------------------
  always_ff @(posedge ref_clk) begin
    for (int u = 0; u < NUM_UNITS; u++) begin
      unit_cfg[u].active <= 1'(lookup(1'b0, UNIT_LDN[u], IDX_ACTIVATE) >> ACTIVATE_BIT);
      unit_cfg[u].base_high <= lookup(1'b0, UNIT_LDN[u], IDX_BASE_HIGH);
      unit_cfg[u].base_low <= lookup(1'b0, UNIT_LDN[u], IDX_BASE_LOW);
      unit_cfg[u].irq_select <= lookup(1'b0, UNIT_LDN[u], IDX_IRQ_SELECT);
      unit_cfg[u].dma_select <= lookup(1'b0, UNIT_LDN[u], IDX_DMA_SELECT);
      unit_cfg[u].mode <= lookup(1'b0, UNIT_LDN[u], IDX_MODE);
    end
  end

  always_ff @(posedge ref_clk) begin
    aux_cfg.power_control <= lookup(1'b1, LDN_NONE, IDX_POWER_CONTROL);
    aux_cfg.test_reg_three <= lookup(1'b1, LDN_NONE, IDX_TEST_REG_THREE);
    aux_cfg.keyboard_reset_gate_select <= lookup(1'b0, LDN_KEYBOARD, IDX_MODE);
    aux_cfg.mouse_irq_select <= lookup(1'b0, LDN_KEYBOARD, IDX_SECOND_IRQ_SELECT);
    aux_cfg.infrared_base_high <= lookup(1'b0, LDN_SERIAL_TWO, IDX_ALT_BASE_HIGH);
    aux_cfg.infrared_base_low <= lookup(1'b0, LDN_SERIAL_TWO, IDX_ALT_BASE_LOW);
    aux_cfg.slow_clock_control <= lookup(1'b0, LDN_RUNTIME, IDX_MODE);
    aux_cfg.floppy_on_parallel_select <= lookup(1'b0, LDN_RUNTIME, IDX_OPTION);
  end

  assign logical_device_q = ldn_q;
  assign soft_reset_pulse = soft_q;

endmodule

// file: testbench/config_bank_monitor.sv
// Concurrent checks on the configuration bank ports
`timescale 1ns/1ps

module config_bank_monitor
  import config_bank_pkg::*;
(
  input wire logic ref_clk,
  input wire logic reset,
  input wire logic main_supply_por,
  input wire logic standby_supply_power_on_reset,
  input wire logic config_enable,
  input wire cfg_req_t cfg_req,
  input wire logic [7:0] cfg_rdata,
  input wire logic cfg_rvalid,
  input wire logic [7:0] logical_device_q,
  input wire logic soft_reset_pulse,
  input wire unit_cfg_t [NUM_UNITS-1:0] unit_cfg,
  input wire aux_cfg_t aux_cfg
);
  // ----------------------------------------------------------------
  // Helper logic
  // ----------------------------------------------------------------
  wire cold = reset | main_supply_por | standby_supply_power_on_reset;
  // Accesses in the soft pulse are left out: reset wins there
  wire take = cfg_req.strobe & config_enable & ~cold & ~soft_reset_pulse;
  wire dwr = take & cfg_req.write & cfg_req.data_port;
  logic [7:0] idx_q;
  always_ff @(posedge ref_clk) begin
    if (cold) idx_q <= 8'h00;
    else if (cfg_req.strobe && config_enable && cfg_req.write && !cfg_req.data_port) idx_q <= cfg_req.wdata;
  end
  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  read_answer_a: assert property (@(posedge ref_clk) disable iff (cold)
    take && !cfg_req.write |=> cfg_rvalid) else $error("read not answered");
  answer_cause_a: assert property (@(posedge ref_clk) disable iff (cold)
    cfg_rvalid |-> $past(cfg_req.strobe && config_enable && !cfg_req.write)) else $error("stray read answer");
  gated_off_a: assert property (@(posedge ref_clk) disable iff (cold)
    !config_enable && cfg_req.strobe |=> !cfg_rvalid) else $error("access while disabled");
  ldn_select_a: assert property (@(posedge ref_clk) disable iff (cold)
    dwr && idx_q == IDX_LDN |=> logical_device_q == $past(cfg_req.wdata)) else $error("ldn not stored");
  soft_trigger_a: assert property (@(posedge ref_clk) disable iff (cold)
    dwr && idx_q == IDX_CONFIG_CONTROL && cfg_req.wdata[SOFT_RESET_BIT] |=> soft_reset_pulse)
    else $error("soft reset not started");
  soft_single_a: assert property (@(posedge ref_clk) disable iff (cold)
    soft_reset_pulse |=> !soft_reset_pulse && logical_device_q == 8'h00) else $error("soft pulse wrong");
  soft_defaults_a: assert property (@(posedge ref_clk) disable iff (cold)
    soft_reset_pulse |-> ##2 !unit_cfg[0].active && unit_cfg[0].base_high == RST_FLOPPY_BASE_HIGH
    && unit_cfg[0].base_low == RST_FLOPPY_BASE_LOW && unit_cfg[0].irq_select == RST_FLOPPY_IRQ
    && unit_cfg[0].dma_select == RST_FLOPPY_DMA && unit_cfg[7].base_low == RST_MIDI_BASE_LOW)
    else $error("soft reset defaults wrong");
  soft_keep_a: assert property (@(posedge ref_clk) disable iff (cold)
    soft_reset_pulse |-> ##2 unit_cfg[0].mode == $past(unit_cfg[0].mode, 2)
    && aux_cfg.test_reg_three == $past(aux_cfg.test_reg_three, 2)) else $error("soft reset lost value");
  standby_only_a: assert property (@(posedge ref_clk) disable iff (standby_supply_power_on_reset)
    reset || main_supply_por |-> ##2
    (aux_cfg.power_control & MASK_POWER_STANDBY) == ($past(aux_cfg.power_control, 2) & MASK_POWER_STANDBY)
    && (aux_cfg.keyboard_reset_gate_select & MASK_KEYBOARD_STANDBY)
    == ($past(aux_cfg.keyboard_reset_gate_select, 2) & MASK_KEYBOARD_STANDBY)
    && aux_cfg.slow_clock_control == $past(aux_cfg.slow_clock_control, 2)
    && aux_cfg.floppy_on_parallel_select == $past(aux_cfg.floppy_on_parallel_select, 2))
    else $error("standby-only field changed");
  hard_keep_a: assert property (@(posedge ref_clk)
    disable iff (main_supply_por || standby_supply_power_on_reset)
    reset |-> ##2 aux_cfg.test_reg_three == $past(aux_cfg.test_reg_three, 2)) else $error("test reg lost");
  por_load_a: assert property (@(posedge ref_clk) disable iff (standby_supply_power_on_reset)
    main_supply_por |-> ##2 aux_cfg.test_reg_three == 8'h00 && unit_cfg[0].mode == RST_FLOPPY_MODE)
    else $error("power-on values wrong");
  soft_seen_c: cover property (@(posedge ref_clk) soft_reset_pulse);
  ldn_seen_c: cover property (@(posedge ref_clk) dwr && idx_q == IDX_LDN);
  hard_seen_c: cover property (@(posedge ref_clk) reset && !standby_supply_power_on_reset);
endmodule

bind logical_device_config_bank config_bank_monitor u_config_bank_monitor (.ref_clk(ref_clk), .reset(reset),
  .main_supply_por(main_supply_por), .standby_supply_power_on_reset(standby_supply_power_on_reset),
  .config_enable(config_enable), .cfg_req(cfg_req), .cfg_rdata(cfg_rdata), .cfg_rvalid(cfg_rvalid),
  .logical_device_q(logical_device_q), .soft_reset_pulse(soft_reset_pulse), .unit_cfg(unit_cfg), .aux_cfg(aux_cfg));

// file: testbench/tb_logical_device_config_bank.sv
// Self-checking bench for the configuration bank
`timescale 1ns/1ps

module tb_logical_device_config_bank
  import config_bank_pkg::*;
;
  logic ref_clk, reset, main_supply_por, standby_supply_power_on_reset, config_enable, cfg_rvalid;
  logic soft_reset_pulse, rv_s;
  logic [7:0] cfg_rdata, logical_device_q, rd_s;
  cfg_req_t cfg_req;
  unit_cfg_t [NUM_UNITS-1:0] unit_cfg;
  aux_cfg_t aux_cfg;
  int err_total, checks_done, cyc;
  // Row: ldn, index, written, after soft reset, after hard reset
  logic [39:0] tab [25] = '{40'h00_60_12_03_03, 40'h00_74_07_02_02, 40'h00_f0_55_55_0e, 40'h00_f1_04_04_00,
    40'h00_f2_3f_3f_ff, 40'h00_f4_66_66_00, 40'h00_2f_44_44_44, 40'h00_22_a1_a0_a0, 40'h00_30_01_00_00,
    40'h03_30_01_00_00, 40'h03_74_01_04_04, 40'h03_f0_11_11_3c, 40'h03_f1_22_22_00, 40'h04_f0_19_19_00,
    40'h05_62_0d_00_00, 40'h05_f1_33_33_02, 40'h05_f2_07_07_03, 40'h05_74_01_04_04, 40'h07_72_09_00_00,
    40'h07_f0_61_61_60, 40'h09_60_07_00_00, 40'h0a_61_08_00_00, 40'h0a_f0_5b_5b_5b, 40'h0a_f1_2d_2d_2d,
    40'h0b_61_0a_30_30};
  logic [15:0] rsv [8] = '{16'h00_02, 16'h00_03, 16'h00_28, 16'h00_62, 16'h01_30, 16'h04_74, 16'h05_30, 16'h09_70};

  logical_device_config_bank u_logical_device_config_bank (.ref_clk(ref_clk), .reset(reset),
    .main_supply_por(main_supply_por), .standby_supply_power_on_reset(standby_supply_power_on_reset),
    .config_enable(config_enable), .cfg_req(cfg_req), .cfg_rdata(cfg_rdata), .cfg_rvalid(cfg_rvalid),
    .logical_device_q(logical_device_q), .soft_reset_pulse(soft_reset_pulse), .unit_cfg(unit_cfg), .aux_cfg(aux_cfg));

  initial begin
    ref_clk = 1'b0;
    forever #4 ref_clk = ~ref_clk;
  end
  // ----------------------------------------------------------------
  // Bus and check tasks
  // ----------------------------------------------------------------
  task automatic chk(input logic [63:0] seen, input logic [63:0] exp);
    checks_done++;
    if (seen !== exp) begin
      err_total++;
      $display("MISMATCH %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  // Extra idle cycle keeps the strobe from being set twice in one step
  task automatic acc(input logic w, input logic dp, input logic [7:0] d);
    cfg_req = '{1'b1, w, dp, d};
    @(negedge ref_clk);
    rv_s = cfg_rvalid;
    rd_s = cfg_rdata;
    cfg_req.strobe = 1'b0;
    @(negedge ref_clk);
  endtask
  task automatic sel(input logic [7:0] ldn, input logic [7:0] idx);
    acc(1'b1, 1'b0, IDX_LDN);
    acc(1'b1, 1'b1, ldn);
    chk(logical_device_q, ldn);
    acc(1'b1, 1'b0, idx);
  endtask
  task automatic wr(input logic [7:0] ldn, input logic [7:0] idx, input logic [7:0] val);
    sel(ldn, idx);
    acc(1'b1, 1'b1, val);
  endtask
  task automatic rl(input logic [7:0] ldn, input logic [7:0] idx, input logic [7:0] exp);
    sel(ldn, idx);
    acc(1'b0, 1'b1, 8'h00);
    chk(rv_s, 1'b1);
    chk(rd_s, exp);
  endtask
  task automatic pulse(input logic [2:0] which, input int n);
    {reset, main_supply_por, standby_supply_power_on_reset} = which;
    repeat (n) @(negedge ref_clk);
    {reset, main_supply_por, standby_supply_power_on_reset} = 3'b000;
    repeat (3) @(negedge ref_clk);
  endtask
  task automatic pass(input int col);
    for (int i = 0; i < 25; i++) begin
      rl(tab[i][39:32], tab[i][31:24], tab[i][8*col +: 8]);
    end
  endtask
  function automatic logic [39:0] exp_u(input int u);
    case (u)
      0: exp_u = 40'h03f006020e;
      1: exp_u = 40'h000000043c;
      3: exp_u = 40'h0000000400;
      7: exp_u = 40'h0330050000;
      default: exp_u = 40'h0000000000;
    endcase
  endfunction
  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", checks_done, err_total);
    if (err_total == 0 && checks_done > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task automatic t_defaults();
    for (int u = 0; u < NUM_UNITS; u++) begin
      chk(unit_cfg[u], {1'b0, exp_u(u)});
    end
    chk(aux_cfg, 64'h0);
    rl(8'h00, IDX_EXTRA, 8'hff);
    rl(8'h05, IDX_OPTION, 8'h02);
    rl(8'h05, IDX_EXTRA, 8'h03);
    $display("t_defaults done");
  endtask
  task automatic t_reserved();
    for (int i = 0; i < 8; i++) begin
      wr(rsv[i][15:8], rsv[i][7:0], 8'hfe);
      rl(rsv[i][15:8], rsv[i][7:0], 8'h00);
    end
    $display("t_reserved done");
  endtask
  task automatic t_banks();
    wr(LDN_PARALLEL, IDX_IRQ_SELECT, 8'h07);
    wr(LDN_SERIAL_ONE, IDX_IRQ_SELECT, 8'h0b);
    wr(LDN_PARALLEL, IDX_ACTIVATE, 8'h01);
    rl(LDN_PARALLEL, IDX_IRQ_SELECT, 8'h07);
    rl(LDN_SERIAL_ONE, IDX_IRQ_SELECT, 8'h0b);
    chk({unit_cfg[1].active, unit_cfg[0].active, unit_cfg[1].irq_select}, 10'h207);
    $display("t_banks done");
  endtask
  task automatic t_gate();
    wr(8'h00, IDX_TEST_REG_THREE, 8'h5a);
    config_enable = 1'b0;
    acc(1'b1, 1'b1, 8'h77);
    acc(1'b0, 1'b1, 8'h00);
    chk(rv_s, 1'b0);
    config_enable = 1'b1;
    rl(8'h00, IDX_TEST_REG_THREE, 8'h5a);
    acc(1'b0, 1'b0, 8'h00);
    chk({rv_s, rd_s}, {1'b1, IDX_TEST_REG_THREE});
    $display("t_gate done");
  endtask
  task automatic t_soft();
    for (int i = 0; i < 25; i++) begin
      wr(tab[i][39:32], tab[i][31:24], tab[i][23:16]);
    end
    pass(2);
    wr(8'h00, IDX_CONFIG_CONTROL, 8'h01);
    chk(logical_device_q, 8'h00);
    rl(8'h00, IDX_CONFIG_CONTROL, 8'h00);
    pass(1);
    $display("t_soft done");
  endtask
  task automatic t_power();
    pulse(3'b100, 2);
    pass(0);
    pulse(3'b010, 2);
    chk({aux_cfg.test_reg_three, aux_cfg.slow_clock_control}, 16'h005b);
    chk({aux_cfg.power_control, aux_cfg.keyboard_reset_gate_select}, 16'ha060);
    chk(unit_cfg[0].mode, 8'h0e);
    $display("t_power done");
  endtask

  always @(posedge ref_clk) begin
    cyc++;
    if (cyc == 6000) begin
      err_total++;
      tally_and_finish();
    end
  end

  initial begin
    cfg_req = '0;
    config_enable = 1'b1;
    pulse(3'b111, 6);
    t_defaults();
    t_reserved();
    t_banks();
    t_gate();
    t_soft();
    t_power();
    pulse(3'b001, 2);
    t_defaults();
    tally_and_finish();
  end
endmodule
